// File: hdl/spi_ctl_consts.vh
`ifndef SPI_CTL_CONSTS_VH
`define SPI_CTL_CONSTS_VH
// Data byte width and FIFO shape.
`define DATA_W 8
`define FIFO_DEPTH 16
`define FIFO_AW 4
// Serial bit count per transfer and bit-counter width.
`define BITS_PER_XFER 4'h8
`define BITCNT_RESET 4'h0
`define BIT1_INDEX 4'h1
// Reset values of control bits and data bytes.
`define MASTER_RESET 1'b1
`define BYTE_ZERO 8'h00
// Transfer state machine codes.
`define ST_IDLE 2'h0
`define ST_SHIFT 2'h1
`define ST_DONE 2'h2
// Master serial clock divider reload for each rate code; a half bit lasts this value plus one system clocks.
`define HALF_DIV2 8'h01
`define HALF_DIV8 8'h04
`define HALF_DIV32 8'h10
`define HALF_DIV128 8'h40
`endif

// File: hdl/sync_2ff.v
// Two-stage synchroniser for one level coming from outside the clock domain.
module sync_2ff (
  input  wire clk,
  input  wire sys_rst,
  input  wire din,
  output wire dout
);
  reg meta_ff;
  reg sync_ff;

  // The first stage feeds only the second stage to keep metastability contained.
  always @(posedge clk) begin
    if (sys_rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule // sync_2ff

// File: hdl/byte_fifo.v
`include "spi_ctl_consts.vh"
// Synchronous FIFO with valid and ready on both sides.
module byte_fifo #(
  parameter WIDTH = `DATA_W,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW    = `FIFO_AW
) (
  input  wire             clk,
  input  wire             sys_rst,
  input  wire             flush,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      count_ff;
  wire            push;
  wire            pop;

  assign in_ready  = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_ff];

  // Storage is written without reset; only pointers and count need a defined state.
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // Pointer and count bookkeeping; flush empties the queue at once.
  always @(posedge clk) begin
    if (sys_rst || flush) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule // byte_fifo

// File: hdl/spi_irq_buffer_reset_control.v
// Notes on behaviour
// - Transmit request is active while tx-empty and tx interrupt enable are set.
// - Receive request needs rx-full, rx interrupt enable and module enable.
// - One error enable gates both overrun and mode fault onto the shared request.
// - Mode fault reaches the request only with rx, error and detect enables set.
// - Mode fault never sets while mode-fault detection is disabled.
// - Rx-full sets whenever a completed byte enters the receive data register.
// - Tx-empty sets when the last queued byte moves from transmit buffer into shift register.
// - A data write clears tx-empty and holds the byte in the transmit buffer.
// - Status read with rx-full set, then data read, clears rx-full.
// - A master starts a queued byte right after the previous transfer completes.
// - A slave with no new byte retransmits what remains in the shift register.
// - System reset returns all control bits and flags to reset values.
// - While disabled: tx-empty set, transfer aborted, shifter and counter cleared, pins released.
// - Control bits and rx-full, overrun, mode-fault flags survive disable.
// - A master mode fault with detection enabled clears the module enable.
// - In wait mode the block runs and its requests can wake the processor.
// - In stop mode the block freezes without touching register contents.
// - Leaving stop through reset aborts the transfer and fully resets the block.
// - During break with clear disabled, accesses leave flags; pending clears finish later.
// - During break with clear enabled, flags clear normally and stay cleared.
// - During break with clear disabled, data writes neither start nor load anything.
// - Unread receive data at bit-1 capture sets overrun and keeps the old byte.
// - Mode fault clears by status read then control write, only without fault.
`include "spi_ctl_consts.vh"
module spi_irq_buffer_reset_control (
  input  wire                clk,
  input  wire                sys_rst,
  input  wire                ctrl_wr,
  input  wire                module_enable_in,
  input  wire                master_select_in,
  input  wire                tx_irq_enable_in,
  input  wire                rx_irq_enable_in,
  input  wire                error_irq_enable_in,
  input  wire                mode_fault_detect_enable_in,
  input  wire                rate_select_hi_in,
  input  wire                rate_select_lo_in,
  input  wire                status_rd,
  input  wire                data_rd,
  input  wire                data_wr,
  input  wire [`DATA_W-1:0]  data_wr_value,
  input  wire                stop_mode,
  input  wire                break_active,
  input  wire                break_clear_enable,
  input  wire                sclk_in,
  input  wire                sdi_in,
  input  wire                slave_select_n_in,
  output reg  [`DATA_W-1:0]  serial_data_reg,
  output wire                module_enable,
  output wire                master_select,
  output wire                tx_irq_enable,
  output wire                rx_irq_enable,
  output wire                error_irq_enable,
  output wire                mode_fault_detect_enable,
  output wire                rate_select_hi,
  output wire                rate_select_lo,
  output wire                tx_empty_flag,
  output wire                rx_full_flag,
  output wire                overrun_flag,
  output wire                mode_fault_flag,
  output wire                tx_irq,
  output wire                rx_err_irq,
  output wire                buf_ready,
  output wire                sclk_out,
  output wire                sclk_oe,
  output wire                sdo_out,
  output wire                sdo_oe,
  output wire                port_owned
);
  // Control bits, flags and datapath registers.
  reg                 module_enable_ff;
  reg                 master_select_ff;
  reg                 tx_irq_enable_ff;
  reg                 rx_irq_enable_ff;
  reg                 error_irq_enable_ff;
  reg                 mfd_enable_ff;
  reg                 rate_hi_ff;
  reg                 rate_lo_ff;
  reg                 rx_full_ff;
  reg                 overrun_ff;
  reg                 mode_fault_ff;
  reg                 rx_armed_ff;
  reg                 mf_armed_ff;
  reg                 was_stopped_ff;
  reg  [1:0]          state_ff;
  reg  [3:0]          bitcnt_ff;
  reg  [`DATA_W-1:0]  shift_ff;
  reg  [7:0]          div_ff;
  reg                 sclk_ff;
  reg                 sclk_prev_ff;
  reg                 ss_prev_ff;
  reg  [1:0]          nxt_state;
  wire                sclk_s;
  wire                sdi_s;
  wire                ss_n_s;
  wire                q_valid;
  wire [`DATA_W-1:0]  q_data;
  wire                q_pop;
  wire                frozen;
  wire                clr_ok;
  wire                fault_cond;
  wire                master_fault;
  wire                wr_accept;
  wire                rise;
  wire                fall;
  wire                sample_edge;
  wire                shift_edge;
  wire                byte_done;
  wire                bit1_capture;
  wire                mf_clear;
  wire                rx_clear;
  reg  [7:0]          half_div;

  // Pin inputs pass two flops before any logic reads them.
  sync_2ff u_sync_sclk (.clk(clk), .sys_rst(sys_rst), .din(sclk_in), .dout(sclk_s));
  sync_2ff u_sync_sdi (.clk(clk), .sys_rst(sys_rst), .din(sdi_in), .dout(sdi_s));
  sync_2ff u_sync_ss (.clk(clk), .sys_rst(sys_rst), .din(slave_select_n_in), .dout(ss_n_s));

  // Stop freezes everything; break without clear permission blocks flag clears.
  assign frozen       = stop_mode;
  assign clr_ok       = !break_active || break_clear_enable;
  assign fault_cond   = mfd_enable_ff && module_enable_ff && master_select_ff && !ss_n_s;
  assign master_fault = fault_cond;
  assign wr_accept    = data_wr && clr_ok && !frozen;

  // Transmit queue; its ready shows back-pressure toward the writer.
  byte_fifo #(.WIDTH(`DATA_W), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_txq (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .flush     (1'b0),
    .in_data   (data_wr_value),
    .in_valid  (wr_accept && module_enable_ff),
    .in_ready  (buf_ready),
    .out_data  (q_data),
    .out_valid (q_valid),
    .out_ready (q_pop)
  );

  // Tx-empty is high whenever the queue is empty, and forced while disabled.
  assign tx_empty_flag = !q_valid || !module_enable_ff;

  // Rate code picks the master half-bit period.
  always @* begin
    case ({rate_hi_ff, rate_lo_ff})
      2'b00:   half_div = `HALF_DIV2;
      2'b01:   half_div = `HALF_DIV8;
      2'b10:   half_div = `HALF_DIV32;
      default: half_div = `HALF_DIV128;
    endcase
  end

  // Master drives its own clock; a slave follows the sampled link clock.
  wire m_tick = master_select_ff && (state_ff == `ST_SHIFT) && (div_ff == 8'h00);
  assign rise = master_select_ff ? (m_tick && !sclk_ff) : (sclk_s && !sclk_prev_ff && !ss_n_s);
  assign fall = master_select_ff ? (m_tick && sclk_ff) : (!sclk_s && sclk_prev_ff && !ss_n_s);
  // A disable can land while the state still reads shift; the enable term stops a late capture.
  assign sample_edge  = rise && (state_ff == `ST_SHIFT) && module_enable_ff;
  assign shift_edge   = fall && (state_ff == `ST_SHIFT);
  assign byte_done    = sample_edge && (bitcnt_ff == `BITS_PER_XFER - 4'h1);
  assign bit1_capture = sample_edge && (bitcnt_ff == `BIT1_INDEX);
  assign q_pop        = (state_ff == `ST_IDLE) && q_valid && module_enable_ff && !frozen
                        && (master_select_ff || !ss_n_s);

  // Transfer sequencing.
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      `ST_IDLE: begin
        // A selected slave enters shift before its first clock edge, so bit one is not lost.
        if (q_pop || (!master_select_ff && !ss_n_s)) nxt_state = `ST_SHIFT;
      end
      `ST_SHIFT: begin
        if (byte_done) nxt_state = `ST_DONE;
        else if (!master_select_ff && ss_n_s) nxt_state = `ST_IDLE;
      end
      `ST_DONE: nxt_state = `ST_IDLE;
      default:  nxt_state = `ST_IDLE;
    endcase
  end

  // Two-step clears: the first step arms, the second completes if still allowed.
  assign rx_clear = data_rd && rx_armed_ff && clr_ok;
  assign mf_clear = ctrl_wr && mf_armed_ff && clr_ok && !fault_cond;

  // Control, flags and shifter. Sets beat clears in the same cycle.
  always @(posedge clk) begin
    if (sys_rst) begin
      module_enable_ff    <= 1'b0;
      master_select_ff    <= `MASTER_RESET;
      tx_irq_enable_ff    <= 1'b0;
      rx_irq_enable_ff    <= 1'b0;
      error_irq_enable_ff <= 1'b0;
      mfd_enable_ff       <= 1'b0;
      rate_hi_ff          <= 1'b0;
      rate_lo_ff          <= 1'b0;
      rx_full_ff          <= 1'b0;
      overrun_ff          <= 1'b0;
      mode_fault_ff       <= 1'b0;
      rx_armed_ff         <= 1'b0;
      mf_armed_ff         <= 1'b0;
      was_stopped_ff      <= 1'b0;
      state_ff            <= `ST_IDLE;
      bitcnt_ff           <= `BITCNT_RESET;
      shift_ff            <= `BYTE_ZERO;
      div_ff              <= 8'h00;
      sclk_ff             <= 1'b0;
      sclk_prev_ff        <= 1'b0;
      ss_prev_ff          <= 1'b1;
      serial_data_reg     <= `BYTE_ZERO;
    end else if (!frozen) begin
      was_stopped_ff <= 1'b0;
      sclk_prev_ff   <= sclk_s;
      ss_prev_ff     <= ss_n_s;
      if (ctrl_wr) begin
        master_select_ff    <= master_select_in;
        tx_irq_enable_ff    <= tx_irq_enable_in;
        rx_irq_enable_ff    <= rx_irq_enable_in;
        error_irq_enable_ff <= error_irq_enable_in;
        mfd_enable_ff       <= mode_fault_detect_enable_in;
        rate_hi_ff          <= rate_select_hi_in;
        rate_lo_ff          <= rate_select_lo_in;
      end
      // Master fault self-disables; otherwise enable follows software.
      if (master_fault) begin
        module_enable_ff <= 1'b0;
      end else if (ctrl_wr) begin
        module_enable_ff <= module_enable_in;
      end
      // Arming tracks the status read that begins each two-step clear.
      if (status_rd && rx_full_ff) rx_armed_ff <= 1'b1;
      else if (rx_clear) rx_armed_ff <= 1'b0;
      if (status_rd && mode_fault_ff) mf_armed_ff <= 1'b1;
      else if (mf_clear) mf_armed_ff <= 1'b0;
      // Slave fault: select released mid-transfer.
      if (master_fault || (mfd_enable_ff && !master_select_ff && module_enable_ff
          && ss_n_s && !ss_prev_ff && state_ff == `ST_SHIFT)) begin
        mode_fault_ff <= 1'b1;
      end else if (mf_clear) begin
        mode_fault_ff <= 1'b0;
      end
      if (bit1_capture && rx_full_ff) begin
        overrun_ff <= 1'b1;
      end else if (status_rd && data_rd && clr_ok) begin
        overrun_ff <= 1'b0;
      end
      if (byte_done && !overrun_ff && !(rx_full_ff && !rx_clear)) begin
        rx_full_ff      <= 1'b1;
        serial_data_reg <= {shift_ff[`DATA_W-2:0], sdi_s};
      end else if (rx_clear) begin
        rx_full_ff <= 1'b0;
      end
      // Partial reset while disabled; flags and control bits are untouched.
      if (!module_enable_ff) begin
        state_ff  <= `ST_IDLE;
        bitcnt_ff <= `BITCNT_RESET;
        shift_ff  <= `BYTE_ZERO;
        div_ff    <= 8'h00;
        sclk_ff   <= 1'b0;
      end else begin
        state_ff <= nxt_state;
        if (q_pop) begin
          shift_ff  <= q_data;
          bitcnt_ff <= `BITCNT_RESET;
          div_ff    <= half_div;
        end else if (state_ff == `ST_SHIFT) begin
          if (master_select_ff) begin
            div_ff <= (div_ff == 8'h00) ? half_div : div_ff - 8'h01;
            if (m_tick) sclk_ff <= !sclk_ff;
          end
          if (sample_edge) bitcnt_ff <= bitcnt_ff + 4'h1;
          if (sample_edge) shift_ff <= {shift_ff[`DATA_W-2:0], sdi_s};
        end else begin
          sclk_ff   <= 1'b0;
          bitcnt_ff <= `BITCNT_RESET; // Shifter keeps last value for slave reuse.
        end
      end
    end else begin
      was_stopped_ff <= 1'b1;
    end
  end

  // Level requests; wait mode needs nothing special since the block keeps running.
  assign tx_irq     = tx_empty_flag && tx_irq_enable_ff;
  assign rx_err_irq = (rx_full_ff && rx_irq_enable_ff && module_enable_ff)
                    || (rx_irq_enable_ff && error_irq_enable_ff
                        && (overrun_ff || (mode_fault_ff && mfd_enable_ff)));

  // Pins are owned only while enabled; data leaves MSB first.
  assign port_owned = module_enable_ff;
  assign sclk_out   = sclk_ff;
  assign sclk_oe    = module_enable_ff && master_select_ff;
  assign sdo_out    = shift_ff[`DATA_W-1];
  assign sdo_oe     = module_enable_ff && (master_select_ff || !ss_n_s);

  assign module_enable            = module_enable_ff;
  assign master_select            = master_select_ff;
  assign tx_irq_enable            = tx_irq_enable_ff;
  assign rx_irq_enable            = rx_irq_enable_ff;
  assign error_irq_enable         = error_irq_enable_ff;
  assign mode_fault_detect_enable = mfd_enable_ff;
  assign rate_select_hi           = rate_hi_ff;
  assign rate_select_lo           = rate_lo_ff;
  assign rx_full_flag             = rx_full_ff;
  assign overrun_flag             = overrun_ff;
  assign mode_fault_flag          = mode_fault_ff;
endmodule // spi_irq_buffer_reset_control

// File: sim/spi_ctl_checker.sv
module spi_ctl_checker (
  input wire clk,
  input wire sys_rst,
  input wire ctrl_wr,
  input wire status_rd,
  input wire data_rd,
  input wire data_wr,
  input wire stop_mode,
  input wire break_active,
  input wire break_clear_enable,
  input wire module_enable,
  input wire master_select,
  input wire tx_irq_enable,
  input wire rx_irq_enable,
  input wire error_irq_enable,
  input wire mode_fault_detect_enable,
  input wire tx_empty_flag,
  input wire rx_full_flag,
  input wire overrun_flag,
  input wire mode_fault_flag,
  input wire tx_irq,
  input wire rx_err_irq,
  input wire sclk_oe,
  input wire port_owned
);
  // All checks share the system clock, and a reset voids any attempt in flight.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  property p_tx_req;
    tx_irq == (tx_empty_flag && tx_irq_enable);
  endproperty
  a_tx_req: assert property (p_tx_req) else $error("tx request level wrong");
  property p_rx_req;
    rx_full_flag && rx_irq_enable && module_enable |-> rx_err_irq;
  endproperty
  a_rx_req: assert property (p_rx_req) else $error("rx request missing");
  property p_rx_gate;
    !module_enable && !error_irq_enable |-> !rx_err_irq;
  endproperty
  a_rx_gate: assert property (p_rx_gate) else $error("rx request while disabled");
  property p_ovr_req;
    overrun_flag && error_irq_enable && rx_irq_enable |-> rx_err_irq;
  endproperty
  a_ovr_req: assert property (p_ovr_req) else $error("overrun request missing");
  property p_mf_req;
    mode_fault_flag && rx_irq_enable && error_irq_enable && mode_fault_detect_enable
      |-> rx_err_irq;
  endproperty
  a_mf_req: assert property (p_mf_req) else $error("mode fault request missing");
  property p_mf_off;
    !mode_fault_detect_enable && !mode_fault_flag && !ctrl_wr |=> !mode_fault_flag;
  endproperty
  a_mf_off: assert property (p_mf_off) else $error("mode fault set undetected");
  property p_brk_wr;
    break_active && !break_clear_enable && data_wr && tx_empty_flag |=> tx_empty_flag;
  endproperty
  a_brk_wr: assert property (p_brk_wr) else $error("break write took effect");
  // The past term skips the first disabled cycle; the pin enables drop in that same cycle.
  property p_off_state;
    !module_enable && !$past(module_enable) |-> tx_empty_flag && !sclk_oe && !port_owned;
  endproperty
  a_off_state: assert property (p_off_state) else $error("disabled state wrong");
  property p_off_keep;
    !module_enable && !ctrl_wr && !status_rd && !data_rd
      |=> $stable({rx_full_flag, overrun_flag, mode_fault_flag, error_irq_enable});
  endproperty
  a_off_keep: assert property (p_off_keep) else $error("state lost while disabled");
  property p_stop_hold;
    stop_mode |=> $stable({module_enable, tx_empty_flag, rx_full_flag, overrun_flag});
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("state moved in stop");
  property p_rst_vals;
    $fell(sys_rst) |-> !module_enable && master_select && tx_empty_flag && !rx_full_flag
      && !overrun_flag && !mode_fault_flag && !tx_irq_enable && !sclk_oe;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
endmodule // spi_ctl_checker

bind spi_irq_buffer_reset_control spi_ctl_checker u_spi_ctl_checker (.*);

// File: sim/spi_far_end.sv
module spi_far_end (
  input  wire  sclk_oe,
  input  wire  fill,
  input  wire  frame_go,
  input  wire  select_low,
  output logic sdi_in,
  output logic sclk_in,
  output logic slave_select_n_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy = 1'b0;
  // Outside a frame, unless the DUT drives the clock, the line shows the opposite level, so stale data cannot pass.
  assign sdi_in = (sclk_oe || busy) ? fill : ~fill;
  assign slave_select_n_in = ~(busy || select_low);
  // As master, eight bits at 400 ns each; the clock idles low between frames.
  always @(posedge frame_go) begin
    busy = 1'b1;
    sclk_in = 1'b0;
    #200;
    repeat (8) begin
      sclk_in = 1'b1;
      #200;
      sclk_in = 1'b0;
      #200;
    end
    busy = 1'b0;
  end
  initial sclk_in = 1'b0;
endmodule // spi_far_end

// File: sim/spi_irq_buffer_reset_control_test.sv
`include "spi_ctl_consts.vh"
module spi_irq_buffer_reset_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, sys_rst = 1'b1, ctrl_wr = 1'b0, status_rd = 1'b0, data_rd = 1'b0;
  logic data_wr = 1'b0, stop_mode = 1'b0, break_active = 1'b0, break_clear_enable = 1'b0;
  logic module_enable_in = 1'b0, master_select_in = 1'b1, tx_irq_enable_in = 1'b0;
  logic rx_irq_enable_in = 1'b0, error_irq_enable_in = 1'b0, mode_fault_detect_enable_in = 1'b0;
  logic rate_select_hi_in = 1'b0, rate_select_lo_in = 1'b0, fill = 1'b1, frame_go = 1'b0;
  logic select_low = 1'b0;
  logic [`DATA_W-1:0] data_wr_value = 8'h00;
  wire [`DATA_W-1:0] serial_data_reg;
  wire module_enable, master_select, tx_irq_enable, rx_irq_enable, error_irq_enable;
  wire mode_fault_detect_enable, rate_select_hi, rate_select_lo, tx_empty_flag, rx_full_flag;
  wire overrun_flag, mode_fault_flag, tx_irq, rx_err_irq, buf_ready, sclk_out, sclk_oe;
  wire sdo_out, sdo_oe, port_owned, sdi_in, sclk_in, slave_select_n_in;
  int num_errors = 0;
  int compares = 0;
  spi_irq_buffer_reset_control u_spi_irq_buffer_reset_control (.*);
  spi_far_end u_spi_far_end (.*);
  always #25 clk = ~clk;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bits: enable, master, tx irq, rx irq, error irq, fault detect.
  task automatic cfg(input logic [5:0] b);
    {module_enable_in, master_select_in, tx_irq_enable_in, rx_irq_enable_in,
     error_irq_enable_in, mode_fault_detect_enable_in} = b;
    ctrl_wr = 1'b1;
    tick(1);
    ctrl_wr = 1'b0;
  endtask
  task automatic wr(input logic [7:0] v);
    data_wr_value = v;
    data_wr = 1'b1;
    tick(1);
    data_wr = 1'b0;
  endtask
  task automatic rd(input logic st, input logic dt);
    status_rd = st;
    data_rd = dt;
    tick(1);
    {status_rd, data_rd} = 2'h0;
  endtask
  // Bounded waits; a missing event shows up in the compare that follows.
  task automatic wait_rx;
    for (int i = 0; i < 400 && rx_full_flag !== 1'b1; i++) tick(1);
  endtask
  task automatic wait_te;
    for (int i = 0; i < 400 && tx_empty_flag !== 1'b1; i++) tick(1);
  endtask
  task automatic test_done;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #500000;
    num_errors++;
    test_done;
  end
  initial begin
    tick(5);
    sys_rst = 1'b0;
    tick(1);
    check("rst", {module_enable, master_select, tx_empty_flag, rx_full_flag}, 8'h06);
    cfg(6'h3E);
    check("tx_irq", tx_irq, 8'h01);
    wr(8'hA5);
    check("tx_empty", {tx_empty_flag, tx_irq}, 8'h00);
    wait_te;
    check("pop", tx_empty_flag, 8'h01);
    wr(8'h3C);
    wait_rx;
    check("rx_full", {rx_full_flag, rx_err_irq}, 8'h03);
    wait_te;
    check("queued", tx_empty_flag, 8'h01);
    rd(1'b1, 1'b0);
    rd(1'b0, 1'b1);
    check("rx_data", serial_data_reg, 8'hFF);
    check("rx_clr", rx_full_flag, 8'h00);
    wait_rx;
    fill = 1'b0;
    wr(8'h0F);
    for (int i = 0; i < 400 && overrun_flag !== 1'b1; i++) tick(1);
    check("ovr", {overrun_flag, rx_err_irq}, 8'h03);
    check("ovr_keep", serial_data_reg, 8'hFF);
    tick(40);
    cfg(6'h30);
    check("err_off", rx_err_irq, 8'h00);
    rd(1'b1, 1'b1);
    check("ovr_clr", overrun_flag, 8'h00);
    rd(1'b1, 1'b0);
    rd(1'b0, 1'b1);
    cfg(6'h3E);
    break_active = 1'b1;
    wr(8'h55);
    check("brk_wr", tx_empty_flag, 8'h01);
    tick(40);
    check("brk_idle", rx_full_flag, 8'h00);
    break_clear_enable = 1'b1;
    wr(8'h55);
    check("brk_ok", tx_empty_flag, 8'h00);
    break_active = 1'b0;
    break_clear_enable = 1'b0;
    wait_rx;
    check("zero", serial_data_reg, 8'h00);
    rd(1'b1, 1'b0);
    break_active = 1'b1;
    rd(1'b0, 1'b1);
    check("brk_keep", rx_full_flag, 8'h01);
    break_active = 1'b0;
    rd(1'b0, 1'b1);
    check("step2", rx_full_flag, 8'h00);
    wr(8'hAA);
    wait_rx;
    {break_active, break_clear_enable} = 2'h3;
    rd(1'b1, 1'b0);
    rd(1'b0, 1'b1);
    {break_active, break_clear_enable} = 2'h0;
    tick(2);
    check("brk_clr", rx_full_flag, 8'h00);
    wr(8'h81);
    wait_rx;
    wr(8'h7E);
    tick(4);
    cfg(6'h16);
    check("off", {tx_empty_flag, port_owned, rx_err_irq}, 8'h04);
    tick(40);
    check("kept", {rx_full_flag, overrun_flag, error_irq_enable}, 8'h05);
    rd(1'b1, 1'b0);
    rd(1'b0, 1'b1);
    cfg(6'h3E);
    wr(8'h42);
    tick(3);
    stop_mode = 1'b1;
    wr(8'h24);
    tick(40);
    check("stop", {rx_full_flag, tx_empty_flag}, 8'h01);
    stop_mode = 1'b0;
    wait_rx;
    check("resume", rx_full_flag, 8'h01);
    rd(1'b1, 1'b0);
    rd(1'b0, 1'b1);
    cfg(6'h3F);
    select_low = 1'b1;
    tick(6);
    check("fault", {mode_fault_flag, module_enable, rx_err_irq}, 8'h05);
    select_low = 1'b0;
    tick(6);
    rd(1'b1, 1'b0);
    cfg(6'h1F);
    check("mf_clr", mode_fault_flag, 8'h00);
    cfg(6'h3E);
    select_low = 1'b1;
    tick(6);
    check("mf_off", {mode_fault_flag, module_enable}, 8'h01);
    select_low = 1'b0;
    fill = 1'b1;
    cfg(6'h2E);
    frame_go = 1'b1;
    tick(1);
    frame_go = 1'b0;
    wait_rx;
    check("slave_rx", {rx_full_flag, serial_data_reg[6:0]}, 8'hFF);
    check("slave_msb", serial_data_reg[7], 8'h01);
    cfg(6'h3E);
    wr(8'h99);
    tick(4);
    stop_mode = 1'b1;
    sys_rst = 1'b1;
    tick(2);
    {sys_rst, stop_mode} = 2'h0;
    tick(40);
    check("stop_rst", {module_enable, master_select, rx_full_flag}, 8'h02);
    test_done;
  end
endmodule // spi_irq_buffer_reset_control_test
